// [sfwp_pkg.sv]
// constants and types of the flash write-protect and status block
// Notes on behaviour
// RULE1: below supply threshold the device stays in reset and decodes nothing
// RULE2: after supply rises, write-class instructions are rejected for the power-up delay; the code ends it early on power-down then release
// RULE3: power-up leaves the write enable latch cleared
// RULE4: program, erase and status writes need the write enable latch set first
// RULE5: finishing a program, erase or status write clears the write enable latch
// RULE6: in power-down only the release instruction is obeyed
// RULE7: 510 block lock bits plus 32 sector lock bits in the end blocks
// RULE8: with individual locks, a set lock bit silently drops program or erase
// RULE9: every lock bit is set at power-on
// RULE10: the unlock instruction 39h clears only the addressed lock bit
// RULE11: scheme select 0 uses range bits only, 1 uses lock bits only
// RULE12: busy bit S0 reads 1 while program, erase or status write runs
// RULE13: while busy only status read and suspend are accepted; the code has no suspend and serves only status reads
// RULE14: busy clears to 0 when the operation completes
// RULE15: write enable sets the read-only latch bit S1
// RULE16: write disable and every program, erase, status write clear the latch
// RULE17: four block-protect bits at S5..S2, written by status write, reset 0
// RULE18: top/bottom select 0 counts the range from the top, 1 from bottom
// RULE19: complement bit S14, reset 0, inverts the protected range
// RULE20: status writes need the status lock to allow it and the latch set
// RULE21: lock 0, protect 1 and write-protect pin low refuse status writes
// RULE22: status lock 1 refuses status writes until the next power cycle
// RULE23: a fixed map of range bits drops program or erase inside the range
package sfwp_pkg;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE    = 8'hd8;
  localparam logic [7:0] OP_CE    = 8'hc7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_SECE  = 8'h44;
  localparam logic [7:0] OP_SECP  = 8'h42;
  localparam logic [7:0] OP_UNLK  = 8'h39;
  localparam logic [7:0] OP_PD    = 8'hb9;
  localparam logic [7:0] OP_RPD   = 8'hab;

  // ----------------------------------------------------------------
  // status field positions and reset values
  // ----------------------------------------------------------------
  localparam int         SR1_BP_LSB = 2;
  localparam int         SR1_TB     = 6;
  localparam int         SR1_SRP    = 7;
  localparam int         SR2_SRL    = 0;
  localparam int         SR2_CMP    = 6;
  localparam int         SR3_WPS    = 2;
  localparam logic [3:0] BP_RST     = 4'h0;
  localparam logic       TB_RST     = 1'b0;
  localparam logic       CMP_RST    = 1'b0;
  localparam logic       WPS_RST    = 1'b0;
  localparam logic       SRP_RST    = 1'b0;
  localparam logic [2:0] PIN_RST    = 3'h3;

  // ----------------------------------------------------------------
  // array geometry and frame layout
  // ----------------------------------------------------------------
  localparam int         NLOCK      = 542;
  localparam int         BLK_LOCKS  = 510;
  localparam logic [9:0] NBLK       = 10'h200;
  localparam logic [6:0] BITS_OP    = 7'h08;
  localparam logic [6:0] BITS_SR    = 7'h10;
  localparam logic [6:0] BITS_ADDR  = 7'h28;
  localparam logic [6:0] BITS_FRAME = 7'h30;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS     = 8;
  localparam int PUW_US     = 5000;
  localparam int PUW_CYC    = (PUW_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int OP_NS      = 1000;
  localparam int OP_CYC     = (OP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [47:0] bits;
    logic [6:0]  nbits;
  } sfwp_frame_t;

  typedef struct packed {
    logic [7:0]  op;
    logic [24:0] addr;
  } sfwp_arr_cmd_t;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h0,
    ST_PUW  = 3'h1,
    ST_RDY  = 3'h3,
    ST_BUSY = 3'h2,
    ST_PDN  = 3'h7
  } sfwp_state_t;

endpackage : sfwp_pkg

// [sfwp_top.sv]
// write-protect, status and lock logic of the serial flash
`timescale 1ns/1ns
`default_nettype none
module sfwp_top #(
  parameter int PUW_CYCLES  = sfwp_pkg::PUW_CYC,
  parameter int BUSY_CYCLES = sfwp_pkg::OP_CYC,
  parameter int TMR_W       = 20
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    supply_ok,
  input  wire logic                    sclk,
  input  wire logic                    cs_n,
  input  wire logic                    di,
  input  wire logic                    wp_n,
  output var  logic                    do_o,
  output var  logic                    do_oe,
  output var  logic [7:0]              status_register_one,
  output var  logic                    arr_cmd_v,
  output var  sfwp_pkg::sfwp_arr_cmd_t arr_cmd
);

  // ----------------------------------------------------------------
  // link side: bit capture on sclk
  // ----------------------------------------------------------------
  logic        armed_q;
  logic [6:0]  cnt_q;
  logic [47:0] sh_q;
  logic [6:0]  cnt_eff;
  logic [24:0] stat_s1_q;
  logic [24:0] stat_s2_q;
  logic [24:0] stat_vec;
  logic [7:0]  rd_byte;
  logic        rd_en;

  // raw chip select only frames the transfer; sclk is quiet outside it
  always_ff @(posedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      armed_q <= 1'b1;
    end else if (cs_n) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  assign cnt_eff = armed_q ? 7'h00 : cnt_q;

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 7'h00;
    end else if (cnt_eff != 7'h7f) begin
      cnt_q <= cnt_eff + 7'h01;
    end else begin
      cnt_q <= cnt_eff;
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q <= 48'h0;
    end else if (cnt_eff < sfwp_pkg::BITS_FRAME) begin
      sh_q[6'd47 - cnt_eff[5:0]] <= di;
    end
  end

  // per-bit sync; bits change only between frames in normal use
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      stat_s1_q <= 25'h0;
      stat_s2_q <= 25'h0;
    end else begin
      stat_s1_q <= stat_vec;
      stat_s2_q <= stat_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // link side: status read-out on falling sclk
  // ----------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    rd_en   = 1'b0;
    if (stat_s2_q[24] && cnt_q >= sfwp_pkg::BITS_OP) begin // RULE6 RULE13
      unique case (sh_q[47:40])
        sfwp_pkg::OP_RDSR1: begin
          rd_byte = stat_s2_q[7:0];
          rd_en   = 1'b1;
        end
        sfwp_pkg::OP_RDSR2: begin
          rd_byte = stat_s2_q[15:8];
          rd_en   = 1'b1;
        end
        sfwp_pkg::OP_RDSR3: begin
          rd_byte = stat_s2_q[23:16];
          rd_en   = 1'b1;
        end
        default: begin
          rd_byte = 8'h00;
          rd_en   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      do_o <= 1'b0;
    end else if (rd_en) begin
      do_o <= rd_byte[~cnt_q[2:0]];
    end
  end

  always_ff @(negedge sclk or posedge cs_n or negedge rst_n) begin
    if (!rst_n) begin
      do_oe <= 1'b0;
    end else if (cs_n) begin
      do_oe <= 1'b0;
    end else begin
      do_oe <= rd_en;
    end
  end

  // ----------------------------------------------------------------
  // core side: pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] p1_q;
  logic [2:0] p2_q;
  logic [2:0] p3_q;
  logic [2:0] pf_q;

  assign pin_raw = {supply_ok, wp_n, cs_n};

  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        p1_q[g] <= sfwp_pkg::PIN_RST[g];
        p2_q[g] <= sfwp_pkg::PIN_RST[g];
        p3_q[g] <= sfwp_pkg::PIN_RST[g];
        pf_q[g] <= sfwp_pkg::PIN_RST[g];
      end else begin
        p1_q[g] <= pin_raw[g];
        p2_q[g] <= p1_q[g];
        p3_q[g] <= p2_q[g];
        if (p2_q[g] == p3_q[g]) begin
          pf_q[g] <= p3_q[g];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // core side: frame hand-over at chip select release
  // ----------------------------------------------------------------
  logic                  cs_prev_q;
  logic                  frm_v_q;
  sfwp_pkg::sfwp_frame_t frm_q;
  logic                  supply_f;

  assign supply_f = pf_q[2];

  // shift state is frozen while cs_n is high, so it is safe to sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_q <= 1'b1;
      frm_v_q   <= 1'b0;
      frm_q     <= '0;
    end else begin
      cs_prev_q <= pf_q[0];
      frm_v_q   <= pf_q[0] && !cs_prev_q;
      if (pf_q[0] && !cs_prev_q) begin
        frm_q <= '{bits: sh_q, nbits: cnt_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // core side: protection lookup
  // ----------------------------------------------------------------
  sfwp_pkg::sfwp_state_t st_q;
  logic [TMR_W-1:0]      tmr_q;
  logic                  busy_q;
  logic                  wel_q;
  logic [3:0]            bp_q;
  logic                  tb_q;
  logic                  cmp_q;
  logic                  wps_q;
  logic                  srp_q;
  logic                  srl_q;
  logic [sfwp_pkg::NLOCK-1:0] lk_q;
  logic [7:0]            op;
  logic [24:0]           addr;
  logic [8:0]            blk;
  logic [9:0]            rng_cnt;
  logic                  in_rng;
  logic [9:0]            lk_idx;
  logic                  prot_addr;
  logic                  prot_any;

  assign op   = frm_q.bits[47:40];
  assign addr = frm_q.bits[32:8];
  assign blk  = addr[24:16];

  // fixed map: each step of the range bits from 1 to 10 doubles the protected blocks
  always_comb begin
    if (bp_q == 4'h0) begin
      rng_cnt = 10'h000;
    end else if (bp_q >= 4'ha) begin
      rng_cnt = sfwp_pkg::NBLK;
    end else begin
      rng_cnt = 10'h001 << (bp_q - 4'h1);
    end
  end

  always_comb begin
    if (tb_q) begin
      in_rng = {1'b0, blk} < rng_cnt; // RULE18
    end else begin
      in_rng = {1'b0, blk} >= (sfwp_pkg::NBLK - rng_cnt); // RULE18
    end
  end

  // end blocks use sector locks, inner blocks one lock each
  always_comb begin
    if (blk == 9'h000) begin
      lk_idx = 10'(sfwp_pkg::BLK_LOCKS) + {6'h00, addr[15:12]}; // RULE7
    end else if (blk == 9'h1ff) begin
      lk_idx = 10'(sfwp_pkg::BLK_LOCKS) + {6'h01, addr[15:12]}; // RULE7
    end else begin
      lk_idx = {1'b0, blk} - 10'h001; // RULE7
    end
  end

  assign prot_addr = wps_q ? lk_q[lk_idx] : (in_rng ^ cmp_q); // RULE11 RULE19 RULE23 RULE8
  assign prot_any  = wps_q ? (|lk_q) :
                     (cmp_q ? (rng_cnt != sfwp_pkg::NBLK) : (rng_cnt != 10'h000)); // RULE11

  // ----------------------------------------------------------------
  // core side: instruction acceptance
  // ----------------------------------------------------------------
  logic rdy;
  logic is_pe;
  logic is_ce;
  logic is_sec;
  logic is_wrsr;
  logic sr_ok;
  logic go_wren;
  logic go_wrdi;
  logic go_wrsr;
  logic go_arr;
  logic go_unlk;
  logic go_pd;
  logic go_rpd;
  logic busy_done;

  assign rdy     = frm_v_q && st_q == sfwp_pkg::ST_RDY; // RULE1 RULE2 RULE13
  assign is_pe   = op == sfwp_pkg::OP_PP || op == sfwp_pkg::OP_QPP ||
                   op == sfwp_pkg::OP_SE || op == sfwp_pkg::OP_BE;
  assign is_ce   = op == sfwp_pkg::OP_CE || op == sfwp_pkg::OP_CE2;
  assign is_sec  = op == sfwp_pkg::OP_SECE || op == sfwp_pkg::OP_SECP;
  assign is_wrsr = op == sfwp_pkg::OP_WRSR1 || op == sfwp_pkg::OP_WRSR2 ||
                   op == sfwp_pkg::OP_WRSR3;
  assign sr_ok   = !srl_q && !(srp_q && !pf_q[1]); // RULE20 RULE21 RULE22

  assign go_wren = rdy && op == sfwp_pkg::OP_WREN; // RULE2
  assign go_wrdi = rdy && op == sfwp_pkg::OP_WRDI;
  assign go_wrsr = rdy && is_wrsr && wel_q && sr_ok &&
                   frm_q.nbits >= sfwp_pkg::BITS_SR; // RULE4 RULE20
  assign go_arr  = rdy && wel_q && frm_q.nbits >= sfwp_pkg::BITS_ADDR &&
                   ((is_pe && !prot_addr) || is_sec) ||
                   rdy && wel_q && is_ce && !prot_any; // RULE4 RULE8 RULE23
  assign go_unlk = rdy && op == sfwp_pkg::OP_UNLK && wel_q &&
                   frm_q.nbits >= sfwp_pkg::BITS_ADDR; // RULE10
  assign go_pd   = frm_v_q && op == sfwp_pkg::OP_PD &&
                   (st_q == sfwp_pkg::ST_RDY || st_q == sfwp_pkg::ST_PUW);
  assign go_rpd  = frm_v_q && op == sfwp_pkg::OP_RPD && st_q == sfwp_pkg::ST_PDN; // RULE6
  assign busy_done = st_q == sfwp_pkg::ST_BUSY && tmr_q == '0;

  // ----------------------------------------------------------------
  // core side: power and busy sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= sfwp_pkg::ST_OFF;
      tmr_q  <= '0;
      busy_q <= 1'b0;
    end else if (!supply_f) begin
      st_q   <= sfwp_pkg::ST_OFF; // RULE1
      tmr_q  <= '0;
      busy_q <= 1'b0;
    end else begin
      unique case (st_q)
        sfwp_pkg::ST_OFF: begin
          st_q  <= sfwp_pkg::ST_PUW;
          tmr_q <= TMR_W'(PUW_CYCLES - 1); // RULE2
        end
        sfwp_pkg::ST_PUW: begin
          if (go_pd) begin
            st_q <= sfwp_pkg::ST_PDN;
          end else if (tmr_q == '0) begin
            st_q <= sfwp_pkg::ST_RDY;
          end else begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
        end
        sfwp_pkg::ST_RDY: begin
          if (go_wrsr || go_arr) begin
            st_q   <= sfwp_pkg::ST_BUSY;
            busy_q <= 1'b1; // RULE12
            tmr_q  <= TMR_W'(BUSY_CYCLES - 1);
          end else if (go_pd) begin
            st_q <= sfwp_pkg::ST_PDN;
          end
        end
        sfwp_pkg::ST_BUSY: begin
          if (tmr_q == '0) begin
            st_q   <= sfwp_pkg::ST_RDY;
            busy_q <= 1'b0; // RULE14
          end else begin
            tmr_q <= tmr_q - TMR_W'(1);
          end
        end
        sfwp_pkg::ST_PDN: begin
          if (go_rpd) begin
            st_q <= sfwp_pkg::ST_RDY; // RULE6
          end
        end
        default: begin
          st_q <= sfwp_pkg::ST_OFF;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core side: write enable latch
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wel_q <= 1'b0; // RULE3
    end else if (!supply_f) begin
      wel_q <= 1'b0; // RULE3
    end else if (busy_done || go_wrdi || go_unlk) begin
      wel_q <= 1'b0; // RULE5 RULE16
    end else if (go_wren) begin
      wel_q <= 1'b1; // RULE15
    end
  end

  // ----------------------------------------------------------------
  // core side: status bits
  // ----------------------------------------------------------------
  // protection bits survive a supply dip; only the lock bit is volatile
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bp_q  <= sfwp_pkg::BP_RST; // RULE17
      tb_q  <= sfwp_pkg::TB_RST; // RULE18
      srp_q <= sfwp_pkg::SRP_RST;
      cmp_q <= sfwp_pkg::CMP_RST; // RULE19
      wps_q <= sfwp_pkg::WPS_RST; // RULE11
      srl_q <= 1'b0;
    end else if (!supply_f) begin
      srl_q <= 1'b0; // RULE22
    end else if (go_wrsr) begin
      unique case (op)
        sfwp_pkg::OP_WRSR1: begin
          bp_q  <= frm_q.bits[32+sfwp_pkg::SR1_BP_LSB +: 4]; // RULE17
          tb_q  <= frm_q.bits[32+sfwp_pkg::SR1_TB];
          srp_q <= frm_q.bits[32+sfwp_pkg::SR1_SRP];
        end
        sfwp_pkg::OP_WRSR2: begin
          srl_q <= frm_q.bits[32+sfwp_pkg::SR2_SRL];
          cmp_q <= frm_q.bits[32+sfwp_pkg::SR2_CMP];
        end
        default: begin
          wps_q <= frm_q.bits[32+sfwp_pkg::SR3_WPS];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // core side: individual lock bits
  // ----------------------------------------------------------------
  for (genvar i = 0; i < sfwp_pkg::NLOCK; i++) begin : g_lock
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        lk_q[i] <= 1'b1; // RULE9
      end else if (!supply_f) begin
        lk_q[i] <= 1'b1; // RULE9
      end else if (go_unlk && lk_idx == 10'(i)) begin
        lk_q[i] <= 1'b0; // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // core side: outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      arr_cmd_v <= 1'b0;
      arr_cmd   <= '0;
    end else begin
      arr_cmd_v <= go_arr;
      if (go_arr) begin
        arr_cmd <= '{op: op, addr: addr};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_register_one <= 8'h00;
    end else begin
      status_register_one <= {srp_q, tb_q, bp_q, wel_q, busy_q}; // RULE12 RULE15
    end
  end

  assign stat_vec = {(st_q != sfwp_pkg::ST_OFF && st_q != sfwp_pkg::ST_PDN),
                     5'h00, wps_q, 2'h0,
                     1'b0, cmp_q, 5'h00, srl_q,
                     srp_q, tb_q, bp_q, wel_q, busy_q};

endmodule : sfwp_top
`default_nettype wire

// [sfwp_chk.sv]
// assertion checker for the flash write-protect block
`timescale 1ns/1ns
`default_nettype none
module sfwp_chk #(
  parameter int PUW_CYCLES  = 50,
  parameter int BUSY_CYCLES = 10
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire logic                    supply_ok,
  input wire logic                    cs_n,
  input wire logic                    do_oe,
  input wire logic [7:0]              status_register_one,
  input wire logic                    arr_cmd_v,
  input wire sfwp_pkg::sfwp_arr_cmd_t arr_cmd
);
  // ------------------------------
  // helper counters
  // ------------------------------
  logic        busy;
  logic        write_enable_latch;
  logic [19:0] on_q;
  logic [19:0] bsy_q;
  logic [3:0]  off_q;
  assign busy = status_register_one[0];
  assign write_enable_latch  = status_register_one[1];
  // counts from the pin, so the window opens before the design's own
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) on_q <= 20'h0;
    else if (!supply_ok) on_q <= 20'h0;
    else if (on_q != 20'hfffff) on_q <= on_q + 20'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) bsy_q <= 20'h0;
    else if (!busy) bsy_q <= 20'h0;
    else bsy_q <= bsy_q + 20'h1;
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) off_q <= 4'h0;
    else if (supply_ok) off_q <= 4'h0;
    else if (off_q != 4'hf) off_q <= off_q + 4'h1;
  end
  // ------------------------------
  // properties
  // ------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_off_quiet: assert property (off_q > 4'h8 |-> !busy && !write_enable_latch && !arr_cmd_v)
    else $error("latch, busy or array op with supply off");
  a_puw_write: assert property (on_q < PUW_CYCLES |-> !$rose(write_enable_latch) && !arr_cmd_v)
    else $error("write accepted in power-up delay");
  a_rise_wel: assert property ($rose(busy) |-> write_enable_latch)
    else $error("busy without latch set");
  a_cmd_busy: assert property (arr_cmd_v |-> ##[0:3] (busy && write_enable_latch))
    else $error("array op without busy");
  a_busy_block: assert property (busy && bsy_q > 20'h4 |-> !arr_cmd_v)
    else $error("array op accepted while busy");
  a_busy_len: assert property (busy |-> bsy_q < BUSY_CYCLES)
    else $error("busy too long");
  a_busy_full: assert property ($fell(busy) && supply_ok |-> bsy_q == BUSY_CYCLES)
    else $error("busy too short");
  a_end_clear: assert property ($fell(busy) && supply_ok |-> !write_enable_latch)
    else $error("latch kept after operation");
  a_pulse_one: assert property (arr_cmd_v |=> !arr_cmd_v)
    else $error("array strobe longer than one cycle");
  a_cmd_hold: assert property (!arr_cmd_v |-> $stable(arr_cmd))
    else $error("array command changed without strobe");
  a_oe_sel: assert property (cs_n |-> !do_oe)
    else $error("output driven while deselected");
  c_cmd: cover property (arr_cmd_v);
  c_done: cover property ($fell(busy));
  c_read: cover property (do_oe);
endmodule : sfwp_chk

bind sfwp_top sfwp_chk #(
  .PUW_CYCLES (PUW_CYCLES),
  .BUSY_CYCLES(BUSY_CYCLES)
) u_chk (
  .clock              (clock),
  .rst_n              (rst_n),
  .supply_ok          (supply_ok),
  .cs_n               (cs_n),
  .do_oe              (do_oe),
  .status_register_one(status_register_one),
  .arr_cmd_v          (arr_cmd_v),
  .arr_cmd            (arr_cmd)
);
`default_nettype wire

// [sfwp_host.sv]
// spi host model issuing flash frames
`timescale 1ns/1ns
`default_nettype none
module sfwp_host (
  output var logic sclk,
  output var logic cs_n,
  output var logic di,
  input wire logic do_o
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    di   = 1'b0;
  end
  // mode 0, clock stands low outside frames, 80 ns period
  task automatic xfer(input logic [47:0] b, input int n, output logic [7:0] r);
    r = 8'h00;
    // keeps link edges off the core clock edges
    #3 cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      di = b[47-i];
      #40 sclk = 1'b1;
      if (i >= 8) r = {r[6:0], do_o};
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    // released line must not keep its last bit
    di = ~di;
    #120;
  endtask : xfer
endmodule : sfwp_host
`default_nettype wire

// [tb_top.sv]
// self-checking bench of the flash write-protect block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int PUW = 400;
  localparam int BSY = 400;
  logic                    clock, rst_n, supply_ok, wp_n, sclk, cs_n, di;
  logic                    do_o, do_oe, arr_cmd_v;
  logic [7:0]              status_register_one, rd;
  sfwp_pkg::sfwp_arr_cmd_t arr_cmd, last_cmd;
  int                      failures, num_checks, npulse;
  always #4 clock = ~clock;
  sfwp_top #(.PUW_CYCLES(PUW), .BUSY_CYCLES(BSY), .TMR_W(20)) uut (
    .clock(clock), .rst_n(rst_n), .supply_ok(supply_ok), .sclk(sclk),
    .cs_n(cs_n), .di(di), .wp_n(wp_n), .do_o(do_o), .do_oe(do_oe),
    .status_register_one(status_register_one), .arr_cmd_v(arr_cmd_v),
    .arr_cmd(arr_cmd));
  sfwp_host host (.sclk(sclk), .cs_n(cs_n), .di(di), .do_o(do_o));
  always @(posedge clock) begin
    if (arr_cmd_v === 1'b1) begin
      npulse++;
      last_cmd = arr_cmd;
    end
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic end_sim;
    if (failures == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic [7:0] o);
    host.xfer({o, 40'h0}, 8, rd);
  endtask : op
  task automatic rdsr(input logic [7:0] e);
    host.xfer({sfwp_pkg::OP_RDSR1, 40'h0}, 16, rd);
    chk(rd, e);
  endtask : rdsr
  task automatic wait_idle;
    int i;
    for (i = 0; i < 1000 && status_register_one[0] !== 1'b0; i++) @(posedge clock);
    if (i == 1000) begin
      failures++;
      end_sim();
    end
  endtask : wait_idle
  // latch first, then the instruction
  task automatic wcmd(input logic [7:0] o, input logic [24:0] a);
    op(sfwp_pkg::OP_WREN);
    host.xfer({o, 7'h0, a, 8'h0}, 40, rd);
  endtask : wcmd
  task automatic wstat(input logic [7:0] o, input logic [7:0] d);
    op(sfwp_pkg::OP_WREN);
    host.xfer({o, d, 32'h0}, 16, rd);
    wait_idle();
  endtask : wstat
  task automatic supply(input logic v);
    @(posedge clock) supply_ok <= v;
    repeat (v ? PUW + 10 : 10) @(posedge clock);
  endtask : supply
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    supply_ok = 1'b0;
    wp_n = 1'b1;
    last_cmd = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    op(sfwp_pkg::OP_WREN);
    chk(status_register_one, 8'h00);
    @(posedge clock) supply_ok <= 1'b1;
    op(sfwp_pkg::OP_WREN);
    chk(status_register_one[1], 1'b0);
    repeat (PUW + 10) @(posedge clock);
    rdsr(8'h00);
    host.xfer({sfwp_pkg::OP_SE, 40'h10000}, 40, rd);
    chk(npulse, 0);
    op(sfwp_pkg::OP_WREN);
    rdsr(8'h02);
    op(sfwp_pkg::OP_WRDI);
    rdsr(8'h00);
    wcmd(sfwp_pkg::OP_SE, 25'h0123000);
    chk(last_cmd, {sfwp_pkg::OP_SE, 25'h0123000});
    rdsr(8'h03);
    op(sfwp_pkg::OP_WRDI);
    chk(status_register_one, 8'h03);
    wait_idle();
    chk(status_register_one, 8'h00);
    // bottom block protected, then complemented
    wstat(sfwp_pkg::OP_WRSR1, 8'h44);
    rdsr(8'h44);
    wcmd(sfwp_pkg::OP_BE, 25'h0);
    chk(npulse, 1);
    wcmd(sfwp_pkg::OP_BE, 25'h1ff0000);
    chk(npulse, 2);
    wait_idle();
    wstat(sfwp_pkg::OP_WRSR2, 8'h40);
    wcmd(sfwp_pkg::OP_BE, 25'h1ff0000);
    chk(npulse, 2);
    wcmd(sfwp_pkg::OP_BE, 25'h0);
    chk(npulse, 3);
    wait_idle();
    wstat(sfwp_pkg::OP_WRSR1, 8'h00);
    op(sfwp_pkg::OP_PD);
    op(sfwp_pkg::OP_WREN);
    chk(status_register_one[1], 1'b0);
    op(sfwp_pkg::OP_RPD);
    op(sfwp_pkg::OP_WREN);
    chk(status_register_one[1], 1'b1);
    // hardware protect pin, then lock-down until a power cycle
    wstat(sfwp_pkg::OP_WRSR1, 8'h80);
    @(posedge clock) wp_n <= 1'b0;
    repeat (6) @(posedge clock);
    wstat(sfwp_pkg::OP_WRSR1, 8'h00);
    chk(status_register_one[7:2], 6'h20);
    @(posedge clock) wp_n <= 1'b1;
    repeat (6) @(posedge clock);
    wstat(sfwp_pkg::OP_WRSR1, 8'h00);
    chk(status_register_one[7:2], 6'h00);
    wstat(sfwp_pkg::OP_WRSR2, 8'h01);
    wstat(sfwp_pkg::OP_WRSR1, 8'h04);
    chk(status_register_one[7:2], 6'h00);
    supply(1'b0);
    supply(1'b1);
    chk(status_register_one, 8'h00);
    wstat(sfwp_pkg::OP_WRSR1, 8'h04);
    chk(status_register_one, 8'h04);
    // individual locks, range bits now ignored
    wstat(sfwp_pkg::OP_WRSR3, 8'h04);
    wcmd(sfwp_pkg::OP_SE, 25'h10000);
    chk(npulse, 3);
    wcmd(sfwp_pkg::OP_UNLK, 25'h10000);
    chk(status_register_one, 8'h04);
    wcmd(sfwp_pkg::OP_SE, 25'h10000);
    chk(npulse, 4);
    wait_idle();
    wcmd(sfwp_pkg::OP_SE, 25'h20000);
    chk(npulse, 4);
    wcmd(sfwp_pkg::OP_UNLK, 25'h1fff000);
    wcmd(sfwp_pkg::OP_SE, 25'h1ffe000);
    chk(npulse, 4);
    wcmd(sfwp_pkg::OP_SE, 25'h1fff000);
    chk(npulse, 5);
    wait_idle();
    wcmd(sfwp_pkg::OP_CE, 25'h0);
    chk(npulse, 5);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
